// ===== src/uird_defines.vh
/*
  Constants of the UART channel control block: register byte
  addresses on the APB bus, reset values, field positions,
  interrupt identification codes.
  Assumes a 32-bit APB bus with one register per aligned word.
*/
`ifndef UIRD_DEFINES_VH
`define UIRD_DEFINES_VH

// Register byte addresses
`define UIRD_A_HOLD    8'h00
`define UIRD_A_IER     8'h04
`define UIRD_A_IIR     8'h08
`define UIRD_A_LCR     8'h0C
`define UIRD_A_MCR     8'h10
`define UIRD_A_LSR     8'h14
`define UIRD_A_MSR     8'h18
`define UIRD_A_SCR     8'h1C
`define UIRD_A_DIVL    8'h20
`define UIRD_A_DIVH    8'h24
`define UIRD_A_EFR     8'h28
`define UIRD_A_XON1    8'h2C
`define UIRD_A_XON2    8'h30
`define UIRD_A_XOFF1   8'h34
`define UIRD_A_XOFF2   8'h38
`define UIRD_A_TCR     8'h3C
`define UIRD_A_TLR     8'h40

// Reset values
`define UIRD_LCR_RST   8'h1D
`define UIRD_ZERO8     8'h00

// Field positions
`define UIRD_FCR_EN    0
`define UIRD_FCR_RXCLR 1
`define UIRD_FCR_TXCLR 2
`define UIRD_FCR_DMA   3
`define UIRD_LCR_BRK   6
`define UIRD_MCR_DTR   0
`define UIRD_MCR_RTS   1
`define UIRD_IER_RX    0
`define UIRD_IER_TX    1
`define UIRD_IER_LS    2
`define UIRD_IER_MS    3
`define UIRD_IER_XOFF  5
`define UIRD_IER_RTS   6
`define UIRD_IER_CTS   7

// Interrupt identification codes
`define UIRD_ID_NONE   6'b00_0001
`define UIRD_ID_LS     6'b00_0110
`define UIRD_ID_TOUT   6'b00_1100
`define UIRD_ID_RX     6'b00_0100
`define UIRD_ID_TX     6'b00_0010
`define UIRD_ID_MS     6'b00_0000
`define UIRD_ID_XOFF   6'b01_0000
`define UIRD_ID_CTS    6'b10_0000

`endif

// ===== src/uird_fifo.v
/*
  Circular FIFO with pointer logic and an occupancy count.
  Assumes the caller never pushes when full or pops when empty
  and that flush wins over push and pop.
*/
`timescale 1ns/1ps
module uird_fifo #(
  parameter W  = 8,
  parameter AW = 6
) (
  input  wire          clk,   // Clock
  input  wire          rstn,  // Async reset, active low
  input  wire          flush, // Clear pointers
  input  wire          push,  // Write din
  input  wire [W-1:0]  din,   // Entry in
  input  wire          pop,   // Drop head
  output wire [W-1:0]  head,  // Entry at head
  output reg  [AW:0]   count  // Entries held
);
  reg [W-1:0]  mem [0:(1<<AW)-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;

  assign head = mem[rp_r];

  always @(posedge clk) begin
    if (push && !flush) begin
      mem[wp_r] <= din;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== src/uird_top.v
/*
  One UART channel: reset states, prioritized interrupt
  identification and DMA request pins for single and block
  transfers, with the register file on APB.
  Assumes the receiver, transmitter and flow-control logic
  outside deliver characters, errors and detection pulses
  synchronous to pclk.
*/
// The implementer's own choices: the address map and the APB register port.
// Behaviour
// - Identification reads 01 after reset
// - Line control resets to 1D
// - Line status resets with bits 5,6
// - Modem deltas cleared, upper bits follow pins
// - Divisors, scratch, flow characters keep values
// - Reset drives serial, RTS, DTR, RX-DMA high
// - Seven enabled interrupt types gate irq
// - Identification reports highest pending source
// - Line status: overrun or FIFO errors
// - Timeout set stale, cleared by RX read
// - RX data by level or trigger
// - TX empty interrupt, cleared INTERRUPT_IDENT_REG/TX_HOLDING_REG
// - Xoff cleared by Xon or LINE_STATUS_REG read (Xon clears only Xoff, the read only special char)
// - CTS/RTS rising edge, cleared INTERRUPT_IDENT_REG read
// - LSR7 set while any FIFO error
// - LINE_STATUS_REG 4:2 show head errors
// - Enabled bits 3:0 give interrupt mode
// - FIFO control bit 3 selects DMA mode
// - Mode 0 or FIFO off: single transfers
// - TX request active when empty
// - RX request active while data held (block mode: set by trigger or timeout, cleared when empty or LSR7)
`timescale 1ns/1ps
`include "uird_defines.vh"
module uird_top #(
  parameter AW = 6
) (
  input  wire        pclk,          // Clock
  input  wire        presetn,       // Async reset, active low
  input  wire        psel,          // APB select
  input  wire        penable,       // APB enable
  input  wire        pwrite,        // APB write
  input  wire [7:0]  paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  output reg  [31:0] prdata,        // APB read data
  output reg         pready,        // APB ready
  output reg         pslverr,       // APB error, unmapped
  input  wire        rx_push,       // Received character strobe
  input  wire [7:0]  rx_char,       // Received character
  input  wire [2:0]  rx_err,        // Break, framing, parity
  input  wire        rx_timeout,    // Stale data strobe
  input  wire        rx_trig_hit,   // RX above trigger level
  input  wire        tx_trig_hit,   // TX passed trigger level
  input  wire        tx_pop,        // Transmitter took head
  input  wire        tx_shift_empty,// Shift register empty
  input  wire        tx_bit,        // Serial bit from shifter
  input  wire        xoff_det,      // Xoff detected strobe
  input  wire        xon_det,       // Xon detected strobe
  input  wire        spec_det,      // Special char strobe
  input  wire        cts_n,         // Clear to send, low
  input  wire        dsr_n,         // Data set ready, low
  input  wire        ri_n,          // Ring indicator, low
  input  wire        cd_n,          // Carrier detect, low
  output reg  [7:0]  tx_char,       // Char at TX FIFO head
  output reg         tx_avail,      // TX FIFO holds data
  output reg         ser_out,       // Serial output
  output reg         rts_n,         // Request to send, low
  output reg         dtr_n,         // Terminal ready, low
  output reg         tx_dma_request_n, // TX request, low
  output reg         rx_dma_request_n, // RX request, low
  output reg         irq_out        // Interrupt, high
);
  localparam [AW:0] DEPTH = 1 << AW;
  localparam [AW:0] ONE   = 1;

  reg  [7:0] ier_r, lcr_r, mcr_r, efr_r, tcr_r, tlr_r;
  reg  [7:0] fcr_r;
  reg  [7:0] divl_r, divh_r, scr_r;
  reg  [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r;
  reg        ovr_r, tout_r, thr_int_r, xflow_r, xspec_r;
  reg        cts_int_r;
  reg  [3:0] msr_d_r;
  reg  [3:0] pin_prev_r;
  reg        primed_r;
  reg        txe_prev_r, txt_prev_r;
  reg  [AW:0] err_cnt_r;

  wire [AW:0]  rx_cnt, tx_cnt;
  wire [10:0]  rx_head;
  wire [7:0]   tx_head;
  wire         setup  = psel & ~penable;
  wire         access = psel & penable & pready;
  wire         wr     = access & pwrite;
  wire         rd     = access & ~pwrite;
  wire [7:0]   wd     = pwdata[7:0];
  wire         fifo_on = fcr_r[`UIRD_FCR_EN];
  wire [AW:0]  limit  = fifo_on ? DEPTH : ONE;
  wire         rx_full = (rx_cnt >= limit);
  wire         tx_full = (tx_cnt >= limit);
  wire         rx_empty = (rx_cnt == {(AW+1){1'b0}});
  wire         tx_empty = (tx_cnt == {(AW+1){1'b0}});

  wire rd_hold = rd & (paddr == `UIRD_A_HOLD);
  wire rd_iir  = rd & (paddr == `UIRD_A_IIR);
  wire rd_lsr  = rd & (paddr == `UIRD_A_LSR);
  wire rd_msr  = rd & (paddr == `UIRD_A_MSR);
  wire wr_hold = wr & (paddr == `UIRD_A_HOLD);
  wire wr_fcr  = wr & (paddr == `UIRD_A_IIR);

  wire rx_acc  = rx_push & ~rx_full;
  wire rx_pop  = rd_hold & ~rx_empty;
  wire tx_acc  = wr_hold & ~tx_full;
  wire tx_take = tx_pop & ~tx_empty;
  wire rx_flush = wr_fcr & wd[`UIRD_FCR_RXCLR];
  wire tx_flush = wr_fcr & wd[`UIRD_FCR_TXCLR];

  uird_fifo #(
    .W  (11),
    .AW (AW)
  ) u_rx (
    .clk   (pclk),
    .rstn  (presetn),
    .flush (rx_flush),
    .push  (rx_acc),
    .din   ({rx_err, rx_char}),
    .pop   (rx_pop),
    .head  (rx_head),
    .count (rx_cnt)
  );

  uird_fifo #(
    .W  (8),
    .AW (AW)
  ) u_tx (
    .clk   (pclk),
    .rstn  (presetn),
    .flush (tx_flush),
    .push  (tx_acc),
    .din   (wd),
    .pop   (tx_take),
    .head  (tx_head),
    .count (tx_cnt)
  );

  // Error bookkeeping over the whole RX FIFO
  wire in_err   = rx_acc & (|rx_err);
  wire head_err = rx_pop & (|rx_head[10:8]);
  wire lsr7     = (err_cnt_r != {(AW+1){1'b0}});
  wire [2:0] head_flags = rx_empty ? 3'b000 : rx_head[10:8];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= {(AW+1){1'b0}};
    end else if (rx_flush) begin
      err_cnt_r <= {(AW+1){1'b0}};
    end else if (in_err && !head_err) begin
      err_cnt_r <= err_cnt_r + ONE;
    end else if (head_err && !in_err) begin
      err_cnt_r <= err_cnt_r - ONE;
    end
  end

  wire [7:0] line_status_reg = {lsr7, tx_empty & tx_shift_empty, tx_empty,
                    head_flags, ovr_r, ~rx_empty};
  wire [3:0] pins = {cd_n, ri_n, dsr_n, cts_n};
  wire [7:0] modem_status_reg  = {~pins, msr_d_r};

  // Pending sources, each gated by its enable
  wire p_ls   = ier_r[`UIRD_IER_LS] & (ovr_r | lsr7);
  wire p_tout = ier_r[`UIRD_IER_RX] & tout_r;
  wire rx_lvl = fifo_on ? rx_trig_hit : ~rx_empty;
  wire p_rx   = ier_r[`UIRD_IER_RX] & rx_lvl;
  wire p_tx   = ier_r[`UIRD_IER_TX] & thr_int_r;
  wire p_ms   = ier_r[`UIRD_IER_MS] & (|msr_d_r);
  wire p_xoff = ier_r[`UIRD_IER_XOFF] & (xflow_r | xspec_r);
  wire p_cts  = (ier_r[`UIRD_IER_RTS] | ier_r[`UIRD_IER_CTS]) &
                cts_int_r;

  reg [5:0] iir_id;
  always @* begin
    iir_id = `UIRD_ID_NONE;
    if (p_ls) begin
      iir_id = `UIRD_ID_LS;
    end else if (p_tout) begin
      iir_id = `UIRD_ID_TOUT;
    end else if (p_rx) begin
      iir_id = `UIRD_ID_RX;
    end else if (p_tx) begin
      iir_id = `UIRD_ID_TX;
    end else if (p_ms) begin
      iir_id = `UIRD_ID_MS;
    end else if (p_xoff) begin
      iir_id = `UIRD_ID_XOFF;
    end else if (p_cts) begin
      iir_id = `UIRD_ID_CTS;
    end
  end

  wire [7:0] interrupt_ident_reg = {fifo_on, fifo_on, iir_id};

  // Read data mux and address decode
  reg [7:0] rmux;
  reg       hit;
  always @* begin
    hit  = 1'b1;
    rmux = 8'h00;
    case (paddr)
      `UIRD_A_HOLD:  rmux = rx_empty ? 8'h00 : rx_head[7:0];
      `UIRD_A_IER:   rmux = ier_r;
      `UIRD_A_IIR:   rmux = interrupt_ident_reg;
      `UIRD_A_LCR:   rmux = lcr_r;
      `UIRD_A_MCR:   rmux = mcr_r;
      `UIRD_A_LSR:   rmux = line_status_reg;
      `UIRD_A_MSR:   rmux = modem_status_reg;
      `UIRD_A_SCR:   rmux = scr_r;
      `UIRD_A_DIVL:  rmux = divl_r;
      `UIRD_A_DIVH:  rmux = divh_r;
      `UIRD_A_EFR:   rmux = efr_r;
      `UIRD_A_XON1:  rmux = xon1_r;
      `UIRD_A_XON2:  rmux = xon2_r;
      `UIRD_A_XOFF1: rmux = xoff1_r;
      `UIRD_A_XOFF2: rmux = xoff2_r;
      `UIRD_A_TCR:   rmux = tcr_r;
      `UIRD_A_TLR:   rmux = tlr_r;
      default:       hit  = 1'b0;
    endcase
  end

  // APB answer: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= {24'h00_0000, pwrite ? 8'h00 : rmux};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Registers set by hardware reset: line control to 1D, the rest cleared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_r <= `UIRD_ZERO8;
      fcr_r <= `UIRD_ZERO8;
      lcr_r <= `UIRD_LCR_RST;
      mcr_r <= `UIRD_ZERO8;
      efr_r <= `UIRD_ZERO8;
      tcr_r <= `UIRD_ZERO8;
      tlr_r <= `UIRD_ZERO8;
    end else if (wr && hit) begin
      case (paddr)
        `UIRD_A_IER: ier_r <= wd;
        `UIRD_A_IIR: fcr_r <= {wd[7:3], 2'b00, wd[0]};
        `UIRD_A_LCR: lcr_r <= wd;
        `UIRD_A_MCR: mcr_r <= wd;
        `UIRD_A_EFR: efr_r <= wd;
        `UIRD_A_TCR: tcr_r <= wd;
        `UIRD_A_TLR: tlr_r <= wd;
        default:     ier_r <= ier_r;
      endcase
    end
  end

  // Registers that hardware reset leaves alone
  always @(posedge pclk) begin
    if (wr) begin
      case (paddr)
        `UIRD_A_SCR:   scr_r   <= wd;
        `UIRD_A_DIVL:  divl_r  <= wd;
        `UIRD_A_DIVH:  divh_r  <= wd;
        `UIRD_A_XON1:  xon1_r  <= wd;
        `UIRD_A_XON2:  xon2_r  <= wd;
        `UIRD_A_XOFF1: xoff1_r <= wd;
        `UIRD_A_XOFF2: xoff2_r <= wd;
        default:       scr_r   <= scr_r;
      endcase
    end
  end

  // Sticky interrupt sources; a set always beats a clear
  wire rd_id_tx  = rd_iir & (prdata[5:0] == `UIRD_ID_TX);
  wire rd_id_cts = rd_iir & (prdata[5:0] == `UIRD_ID_CTS);
  wire txe_rise  = tx_empty & ~txe_prev_r;
  wire txt_rise  = tx_trig_hit & ~txt_prev_r;
  wire thr_set   = fifo_on ? txt_rise : txe_rise;
  wire rts_rise  = ~rts_n & ~mcr_r[`UIRD_MCR_RTS];
  wire cts_rise  = primed_r & cts_n & ~pin_prev_r[0];
  wire cts_set   = (ier_r[`UIRD_IER_RTS] & rts_rise) |
                   (ier_r[`UIRD_IER_CTS] & cts_rise);
  wire [3:0] chg = primed_r ?
                   {pins[3] ^ pin_prev_r[3],
                    pins[2] & ~pin_prev_r[2],
                    pins[1] ^ pin_prev_r[1],
                    pins[0] ^ pin_prev_r[0]} : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r      <= 1'b0;
      tout_r     <= 1'b0;
      thr_int_r  <= 1'b0;
      xflow_r    <= 1'b0;
      xspec_r    <= 1'b0;
      cts_int_r  <= 1'b0;
      msr_d_r    <= 4'h0;
      pin_prev_r <= 4'hF;
      primed_r   <= 1'b0;
      txe_prev_r <= 1'b1;
      txt_prev_r <= 1'b0;
    end else begin
      primed_r   <= 1'b1;
      pin_prev_r <= pins;
      txe_prev_r <= tx_empty;
      txt_prev_r <= tx_trig_hit;
      ovr_r <= (rx_push & rx_full) | (ovr_r & ~rd_lsr);
      tout_r <= rx_timeout | (tout_r & ~rd_hold);
      thr_int_r <= thr_set |
                   (thr_int_r & ~rd_id_tx & ~wr_hold);
      xflow_r <= xoff_det | (xflow_r & ~xon_det);
      xspec_r <= spec_det | (xspec_r & ~rd_lsr);
      cts_int_r <= cts_set | (cts_int_r & ~rd_id_cts);
      msr_d_r <= chg | (msr_d_r & {4{~rd_msr}});
    end
  end

  // DMA requests, active low on the pins
  wire single = ~fifo_on | ~fcr_r[`UIRD_FCR_DMA];
  wire txrq   = single ? tx_empty : ~tx_full;
  reg  rxrq_blk_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxrq_blk_r <= 1'b0;
    end else if (rx_empty || lsr7) begin
      rxrq_blk_r <= 1'b0;
    end else if (rx_trig_hit || rx_timeout) begin
      rxrq_blk_r <= 1'b1;
    end
  end
  wire rxrq = single ? ~rx_empty : rxrq_blk_r;

  // Pin outputs, all straight from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_out          <= 1'b1;
      rts_n            <= 1'b1;
      dtr_n            <= 1'b1;
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b0;
      irq_out          <= 1'b0;
      tx_char          <= 8'h00;
      tx_avail         <= 1'b0;
    end else begin
      ser_out  <= tx_bit & ~lcr_r[`UIRD_LCR_BRK];
      rts_n    <= ~mcr_r[`UIRD_MCR_RTS];
      dtr_n    <= ~mcr_r[`UIRD_MCR_DTR];
      rx_dma_request_n <= ~rxrq;
      tx_dma_request_n <= ~txrq;
      irq_out  <= (iir_id != `UIRD_ID_NONE);
      tx_char  <= tx_head;
      tx_avail <= ~tx_empty;
    end
  end
endmodule

// ===== verif/uird_props.sv
/*
  Port checker for the UART channel control block.
  Assumes it is bound to uird_top and shares its defines header.
*/
`timescale 1ns/1ps
`include "uird_defines.vh"
module uird_props (
  input wire        pclk, presetn, psel, penable, pwrite, pready,
  input wire        pslverr, rx_push, ser_out, rts_n, dtr_n, irq_out,
  input wire        tx_dma_request_n, rx_dma_request_n,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata, prdata
);
  reg  [7:0] ier_r, lcr_r, mcr_r, fcr_r;
  wire       acc     = psel && penable && pready;
  wire       wr_a    = acc && pwrite;
  wire       hold_rd = acc && !pwrite && paddr == `UIRD_A_HOLD;
  wire       single  = !fcr_r[0] || !fcr_r[3];
  // Shadow of the control registers as written over APB
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_r <= 8'h00;
      lcr_r <= `UIRD_LCR_RST;
      mcr_r <= 8'h00;
      fcr_r <= 8'h00;
    end else if (wr_a) begin
      if (paddr == `UIRD_A_IER) ier_r <= pwdata[7:0];
      if (paddr == `UIRD_A_LCR) lcr_r <= pwdata[7:0];
      if (paddr == `UIRD_A_MCR) mcr_r <= pwdata[7:0];
      if (paddr == `UIRD_A_IIR) fcr_r <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rst_pins: assert property ($rose(presetn) |-> ser_out && rts_n &&
    dtr_n && rx_dma_request_n && !tx_dma_request_n && !irq_out)
    else $error("pins wrong after reset");
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  a_err_unmap: assert property (psel && !penable && paddr > 8'h40
    |=> pslverr && prdata == 32'h0000_0000) else $error("unmapped ok");
  a_err_mapped: assert property (psel && !penable && paddr <= 8'h40 &&
    paddr[1:0] == 2'b00 |=> !pslverr) else $error("mapped refused");
  a_rx_req_on: assert property (rx_push && single && !hold_rd ##1
    !hold_rd |-> ##1 !rx_dma_request_n) else $error("rx request off");
  a_rx_req_off: assert property (hold_rd && !fcr_r[0] && !rx_push ##1
    !rx_push |-> ##1 rx_dma_request_n) else $error("rx request on");
  a_tx_req_load: assert property (wr_a && paddr == `UIRD_A_HOLD &&
    single |-> ##[1:2] tx_dma_request_n) else $error("tx request on");
  a_irq_polled: assert property ((ier_r == 8'h00) [*3] |-> !irq_out)
    else $error("irq while disabled");
  a_modem_pins: assert property (wr_a && paddr == `UIRD_A_MCR |=> ##1
    rts_n == !mcr_r[1] && dtr_n == !mcr_r[0]) else $error("modem pins");
  a_brk_low: assert property (lcr_r[6] [*3] |-> !ser_out)
    else $error("break not low");
  c_hold_rd: cover property (hold_rd);
  c_tx_req: cover property ($fell(tx_dma_request_n));
  c_irq: cover property ($rose(irq_out));
endmodule

// ===== verif/uird_host.sv
/*
  Host model: APB master and the queue of expected read results.
  Assumes pclk comes from the bench and the slave may wait.
*/
`timescale 1ns/1ps
module uird_host (
  input  wire        pclk,    // Clock
  input  wire        pready,  // APB ready
  output reg         psel,    // APB select
  output reg         penable, // APB enable
  output reg         pwrite,  // APB direction
  output reg  [7:0]  paddr,   // APB address
  output reg  [31:0] pwdata   // APB write data
);
  logic [8:0] exp_q [$];
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One transfer; e holds the expected {pslverr, byte} of a read
  task xfer(input w, input [7:0] a, input [7:0] d, input [8:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== verif/tb_uart_irq_reset_dma_ready.sv
/*
  Self-checking bench for the UART channel control block.
  Assumes design files and defines header compile first; the host
  model drives APB, this module the line-side inputs.
*/
`timescale 1ns/1ps
`include "uird_defines.vh"
module tb_uart_irq_reset_dma_ready;
  localparam [63:0] RA = {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28,
                          8'h3C, 8'h40};
  localparam [63:0] RV = {8'h00, 8'h01, 8'h1D, 8'h00, 8'h60, 8'h00,
                          8'h00, 8'h00};
  localparam [55:0] PA = {8'h1C, 8'h20, 8'h24, 8'h2C, 8'h30, 8'h34,
                          8'h38};
  reg         pclk, presetn, rx_push, rx_timeout, rx_trig_hit, tx_pop;
  reg         tx_trig_hit, tx_shift_empty, tx_bit, xoff_det, xon_det;
  reg         spec_det, cts_n, dsr_n, ri_n, cd_n;
  reg  [7:0]  rx_char, c, c0;
  reg  [2:0]  rx_err;
  reg  [8:0]  e;
  reg  [7:0]  pv [0:6];
  wire        psel, penable, pwrite, pready, pslverr, tx_avail, ser_out;
  wire        rts_n, dtr_n, tx_dma_request_n, rx_dma_request_n, irq_out;
  wire [7:0]  paddr, tx_char;
  wire [31:0] pwdata, prdata;
  wire [4:0]  rst_pins = {ser_out, rts_n, dtr_n, rx_dma_request_n,
                          tx_dma_request_n};
  integer     seed, i, fail_count, n_compared;

  uird_top dut_u (.*);
  uird_host host_u (.*);

  task rd(input [7:0] a, input [7:0] x);
    host_u.xfer(1'b0, a, 8'h00, {1'b0, x});
  endtask
  task wr(input [7:0] a, input [7:0] d);
    host_u.xfer(1'b1, a, d, 9'h000);
  endtask
  task chk(input [7:0] g, input [7:0] x);
    n_compared = n_compared + 1;
    if (g !== x) begin
      fail_count = fail_count + 1;
      $display("Error %0t pin %h exp %h", $time, g, x);
    end
  endtask
  task pulse(input [4:0] m);
    @(posedge pclk);
    {tx_pop, spec_det, xon_det, xoff_det, rx_timeout} <= m;
    @(posedge pclk);
    {tx_pop, spec_det, xon_det, xoff_det, rx_timeout} <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask
  task push(input [2:0] er);
    c = $random(seed);
    @(posedge pclk);
    rx_push <= 1'b1;
    rx_char <= c;
    rx_err <= er;
    @(posedge pclk);
    rx_push <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task rst_regs(input [7:0] modem_status_reg);
    for (i = 0; i < 8; i = i + 1)
      rd(RA[i*8 +: 8], RV[i*8 +: 8]);
    rd(`UIRD_A_MSR, modem_status_reg);
  endtask
  task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Read results leave the host queue in issue order
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = host_u.exp_q.pop_front();
      n_compared = n_compared + 1;
      if ({pslverr, prdata} !== {e[8], 24'h00_0000, e[7:0]}) begin
        fail_count = fail_count + 1;
        $display("Error %0t read %h exp %h", $time, prdata, e);
      end
    end
  end
  always @(posedge pclk) tx_bit <= $random(seed);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count = fail_count + 1;
    $display("Error %0t timeout", $time);
    summarize;
  end

  initial begin
    seed = 32'hc61f;
    fail_count = 0;
    n_compared = 0;
    presetn = 1'b0;
    {rx_push, rx_timeout, rx_trig_hit, tx_trig_hit, tx_pop} = 5'h00;
    {xoff_det, xon_det, spec_det, cts_n, cd_n} = 5'h00;
    {tx_shift_empty, tx_bit, dsr_n, ri_n} = 4'hF;
    rx_char = 8'h00;
    rx_err = 3'h0;
    repeat (8) @(posedge pclk);
    chk(rst_pins, 8'h1E);
    presetn <= 1'b1;
    rst_regs(8'h90);
    for (i = 0; i < 7; i = i + 1) begin
      pv[i] = $random(seed);
      wr(PA[i*8 +: 8], pv[i]);
    end
    wr(`UIRD_A_IER, 8'h0F);
    @(posedge pclk);
    presetn <= 1'b0;
    dsr_n <= 1'b0;
    cd_n <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(rst_pins, 8'h1E);
    presetn <= 1'b1;
    rst_regs(8'h30);
    for (i = 0; i < 7; i = i + 1)
      rd(PA[i*8 +: 8], pv[i]);
    host_u.xfer(1'b0, 8'h44, 8'h00, 9'h100);
    wr(`UIRD_A_IER, 8'h05);
    push(3'h0);
    chk({irq_out, rx_dma_request_n}, 8'h02);
    rd(`UIRD_A_LSR, 8'h61);
    rd(`UIRD_A_IIR, 8'h04);
    rd(`UIRD_A_HOLD, c);
    rd(`UIRD_A_IIR, 8'h01);
    chk(rx_dma_request_n, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
      push(3'h1 << i);
      rd(`UIRD_A_LSR, 8'hE1 | (8'h04 << i));
      rd(`UIRD_A_IIR, 8'h06);
      rd(`UIRD_A_HOLD, c);
      rd(`UIRD_A_LSR, 8'h60);
    end
    push(3'h0);
    c0 = c;
    push(3'h0);
    rd(`UIRD_A_IIR, 8'h06);
    rd(`UIRD_A_LSR, 8'h63);
    rd(`UIRD_A_IIR, 8'h04);
    rd(`UIRD_A_HOLD, c0);
    push(3'h0);
    pulse(5'h01);
    rd(`UIRD_A_IIR, 8'h0C);
    rd(`UIRD_A_HOLD, c);
    rd(`UIRD_A_IIR, 8'h01);
    wr(`UIRD_A_IER, 8'h00);
    push(3'h0);
    chk(irq_out, 8'h00);
    rd(`UIRD_A_LSR, 8'h61);
    rd(`UIRD_A_HOLD, c);
    wr(`UIRD_A_IER, 8'h02);
    c = $random(seed);
    wr(`UIRD_A_HOLD, c);
    repeat (2) @(posedge pclk);
    chk({tx_avail, tx_dma_request_n}, 8'h03);
    chk(tx_char, c);
    rd(`UIRD_A_IIR, 8'h01);
    pulse(5'h10);
    chk({irq_out, tx_dma_request_n}, 8'h02);
    rd(`UIRD_A_IIR, 8'h02);
    rd(`UIRD_A_IIR, 8'h01);
    wr(`UIRD_A_IER, 8'hC0);
    wr(`UIRD_A_MCR, 8'h02);
    wr(`UIRD_A_MCR, 8'h00);
    rd(`UIRD_A_IIR, 8'h20);
    rd(`UIRD_A_IIR, 8'h01);
    @(posedge pclk);
    cts_n <= 1'b1;
    rd(`UIRD_A_IIR, 8'h20);
    rd(`UIRD_A_IIR, 8'h01);
    wr(`UIRD_A_IER, 8'h20);
    pulse(5'h02);
    rd(`UIRD_A_IIR, 8'h10);
    pulse(5'h04);
    rd(`UIRD_A_IIR, 8'h01);
    pulse(5'h08);
    rd(`UIRD_A_IIR, 8'h10);
    rd(`UIRD_A_LSR, 8'h60);
    rd(`UIRD_A_IIR, 8'h01);
    wr(`UIRD_A_IER, 8'h08);
    rd(`UIRD_A_IIR, 8'h00);
    rd(`UIRD_A_MSR, 8'h21);
    rd(`UIRD_A_IIR, 8'h01);
    wr(`UIRD_A_IIR, 8'h01);
    push(3'h0);
    c0 = c;
    push(3'h1);
    chk(rx_dma_request_n, 8'h00);
    wr(`UIRD_A_IER, 8'h01);
    rd(`UIRD_A_IIR, 8'hC1);
    @(posedge pclk);
    rx_trig_hit <= 1'b1;
    rd(`UIRD_A_IIR, 8'hC4);
    rx_trig_hit <= 1'b0;
    rd(`UIRD_A_LSR, 8'hE1);
    rd(`UIRD_A_HOLD, c0);
    rd(`UIRD_A_LSR, 8'hE5);
    rd(`UIRD_A_HOLD, c);
    rd(`UIRD_A_LSR, 8'h60);
    // FIFO on: mode 0 drops the TX request on a load, mode 1 keeps it
    for (i = 0; i < 2; i = i + 1) begin
      wr(`UIRD_A_IIR, i ? 8'h09 : 8'h01);
      wr(`UIRD_A_HOLD, c);
      repeat (2) @(posedge pclk);
      chk(tx_dma_request_n, i ? 8'h00 : 8'h01);
      pulse(5'h10);
    end
    wr(`UIRD_A_LCR, 8'h5D);
    repeat (2) @(posedge pclk);
    chk(ser_out, 8'h00);
    wr(`UIRD_A_LCR, 8'h1D);
    repeat (3) @(posedge pclk);
    summarize;
  end
endmodule

bind uird_top uird_props chk_u (.*);
